// ==== isc_slave.sv ====
// Command, acknowledge and status logic of the two-wire bus slave
`timescale 1ns/1ns

// Summary of operation
// - Ack action runs on shift data access or an executing command write
// - Ack select is a plain stored bit; 0 sends ACK, 1 sends NACK
// - Command field bits 1:0 are write strobes and read as zero
// - Code 0 does nothing; code 1 is reserved and must not be written
// - Complete code: direction 0 acks then waits for start; direction 1 only waits
// - Response after address: ack, then receive (dir 0) or data flag (dir 1)
// - Response after data: dir 0 ack then receive; dir 1 send byte, take ack
// - Ack select and command written together use the new ack value
// - Smart-mode shift data access or a valid command write clears data-done and address-or-stop flags
// - Data-done bit 7 sets on finished byte, also after a collision
// - Data-done clears by writing 1, data access or valid command
// - Address-or-stop bit 6 sets on address match or stop; clears like data-done
// - Pending address or data flag holds SCL low, shown in bit 5
// - Bit 4 keeps the last acknowledge received from the master
// - Collision bit 3 on failed high bit; then never drive SDA low
// - Collision clears by writing 1 or on any start condition
// - NACK collision after address leaves address-or-stop flag set
// - Bus error bit 2 on misplaced start or stop; write 1 clears
// - Bus errors detected only with detector enabled and clock at least 4x SCL
// - Bit 1 shows direction bit of the last received address
// - Bit 0 tells stop (0) or address (1) as address-or-stop cause
// - Own address bits 7:1 hold address; bit 0 enables general call
// - Stop sets address-or-stop flag only with stop flag enable
// - Smart mode lets data access continue; otherwise a command is needed
module isc_slave
  import isc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [isc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe
);

  typedef struct packed {
    isc_state_t st;
    isc_state_t after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] own_address;
    logic [7:0] slv_ctrl;
    logic       ack_action_select;
    logic       received_ack_bit;
    logic       dir;
    logic       addr_or_stop_cause;
    logic       from_addr;
    logic       scl_oe;
    logic       sda_oe;
    logic [7:0] rdata;
  } isc_core_state_t;

  isc_core_state_t r;
  isc_core_state_t next_r;

  logic [NUM_FLAGS-1:0] flag_q;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flag_nx;
  logic                 addr_hit;
  logic                 go;

  isc_line_if line ();

  isc_line_det u_det (
    .clk     (clk),
    .sys_rst (sys_rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .line    (line)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++)
    begin : g_flag
      isc_flag u_flag (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set     (flag_set[gi]),
        .clr     (flag_clr[gi]),
        .q       (flag_q[gi])
      );
    end
  endgenerate

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic is_hold(input isc_state_t s);
    is_hold = (s == ST_HOLD_ADDR) || (s == ST_HOLD_DATA);
  endfunction

  function automatic logic is_shift(input isc_state_t s);
    is_shift = (s == ST_RX_ADDR) || (s == ST_RX_BYTE) || (s == ST_TX_BYTE);
  endfunction

  always_comb
  begin
    logic       wr_cmd;
    logic       data_acc;
    logic       valid_cmd;
    logic       ack_val;
    logic       berr_ok;
    logic [1:0] cmd;
    next_r    = r;
    flag_set  = '0;
    flag_clr  = '0;
    addr_hit  = 1'b0;
    cmd       = reg_wdata[1:0];
    wr_cmd    = reg_wr && hit(reg_addr, OFF_CMD_CTRL);
    berr_ok   = r.slv_ctrl[CTL_BERR];
    // Data access only drives the protocol in smart mode
    data_acc  = (reg_wr || reg_rd) && hit(reg_addr, OFF_SHIFT_DATA)
                && r.slv_ctrl[CTL_SMART];
    // Codes 0 and 1 are ignored
    valid_cmd = wr_cmd && (cmd == COMPLETE_TRANSACTION_CODE
                           || cmd == RESPONSE_CODE);
    go        = valid_cmd || data_acc;
    ack_val   = wr_cmd ? reg_wdata[CMD_ACK_BIT] : r.ack_action_select;

    if (go)
    begin
      flag_clr[FI_DONE] = 1'b1;
      flag_clr[FI_ADST] = 1'b1;
    end

    if (reg_wr)
    begin
      if (hit(reg_addr, OFF_SLV_CTRL))
        next_r.slv_ctrl = reg_wdata;
      if (wr_cmd)
        next_r.ack_action_select = reg_wdata[CMD_ACK_BIT];
      if (hit(reg_addr, OFF_OWN_ADDR))
        next_r.own_address = reg_wdata;
      if (hit(reg_addr, OFF_FLAGS))
      begin
        flag_clr[FI_DONE]  = flag_clr[FI_DONE] | reg_wdata[FLG_DATA_DONE];
        flag_clr[FI_ADST]  = flag_clr[FI_ADST] | reg_wdata[FLG_ADDR_STOP];
        flag_clr[FI_CLASH] = reg_wdata[FLG_COLLISION];
        flag_clr[FI_BERR] = reg_wdata[FLG_BUS_ERROR];
      end
      // Shifting owns the register; writes land only outside the address, receive and transmit states
      if (hit(reg_addr, OFF_SHIFT_DATA) && !is_shift(r.st))
        next_r.shreg = reg_wdata;
    end

    if (reg_rd)
    begin
      case (reg_addr)
        OFF_SLV_CTRL:   next_r.rdata = r.slv_ctrl;
        OFF_CMD_CTRL:   next_r.rdata = {5'h00, r.ack_action_select, 2'h0};
        OFF_FLAGS:      next_r.rdata = {flag_q[FI_DONE], flag_q[FI_ADST], r.scl_oe,
                                        r.received_ack_bit, flag_q[FI_CLASH],
                                        flag_q[FI_BERR], r.dir, r.addr_or_stop_cause};
        OFF_OWN_ADDR:   next_r.rdata = r.own_address;
        OFF_SHIFT_DATA: next_r.rdata = r.shreg;
        default:        next_r.rdata = 8'h00;
      endcase
    end

    case (r.st)
      ST_RX_ADDR:
      begin
        if (line.scl_rise)
        begin
          next_r.shreg   = {r.shreg[6:0], line.sda};
          next_r.bit_cnt = r.bit_cnt + 4'h1;
        end
        else if (line.scl_fall && r.bit_cnt == BITS_PER_BYTE)
        begin
          next_r.bit_cnt = 4'h0;
          if (r.shreg[7:1] == r.own_address[7:1]
              || (r.shreg[7:1] == 7'h00 && r.own_address[0]))
          begin
            addr_hit                  = 1'b1;
            flag_set[FI_ADST]         = 1'b1;
            next_r.addr_or_stop_cause = 1'b1;
            next_r.dir                = r.shreg[0];
            next_r.from_addr          = 1'b1;
            next_r.st                 = ST_HOLD_ADDR;
          end
          else
            next_r.st = ST_WAIT_START;
        end
      end
      ST_HOLD_ADDR, ST_HOLD_DATA:
      begin
        if (go)
        begin
          next_r.bit_cnt = 4'h0;
          if (valid_cmd && cmd == COMPLETE_TRANSACTION_CODE)
          begin
            next_r.after_ack = ST_WAIT_START;
            next_r.st        = r.dir ? ST_WAIT_START : ST_ACK_OUT;
          end
          else if (r.st == ST_HOLD_ADDR)
          begin
            next_r.after_ack = r.dir ? ST_HOLD_DATA : ST_RX_BYTE;
            next_r.st        = ST_ACK_OUT;
          end
          else
          begin
            next_r.after_ack = ST_RX_BYTE;
            next_r.st        = r.dir ? ST_TX_BYTE : ST_ACK_OUT;
          end
        end
      end
      ST_ACK_OUT:
      begin
        if (line.scl_rise && r.ack_action_select && !line.sda)
        begin
          flag_set[FI_CLASH] = 1'b1;
          if (r.from_addr)
          begin
            flag_set[FI_ADST]         = 1'b1;
            next_r.addr_or_stop_cause = 1'b1;
          end
        end
        else if (line.scl_fall)
        begin
          next_r.st        = r.after_ack;
          next_r.from_addr = 1'b0;
          if (r.after_ack == ST_HOLD_DATA)
            flag_set[FI_DONE] = 1'b1;
        end
      end
      ST_RX_BYTE:
      begin
        if (line.scl_rise)
        begin
          next_r.shreg   = {r.shreg[6:0], line.sda};
          next_r.bit_cnt = r.bit_cnt + 4'h1;
        end
        else if (line.scl_fall && r.bit_cnt == BITS_PER_BYTE)
        begin
          flag_set[FI_DONE] = 1'b1;
          next_r.bit_cnt   = 4'h0;
          next_r.st        = ST_HOLD_DATA;
        end
      end
      ST_TX_BYTE:
      begin
        if (line.scl_rise)
        begin
          if (r.shreg[7] && !line.sda)
            flag_set[FI_CLASH] = 1'b1;
          next_r.bit_cnt = r.bit_cnt + 4'h1;
        end
        else if (line.scl_fall)
        begin
          next_r.shreg = {r.shreg[6:0], 1'b1};
          if (r.bit_cnt == BITS_PER_BYTE)
          begin
            next_r.bit_cnt = 4'h0;
            next_r.st      = ST_ACK_IN;
          end
        end
      end
      ST_ACK_IN:
      begin
        if (line.scl_rise)
          next_r.received_ack_bit = line.sda;
        else if (line.scl_fall)
        begin
          // Ends a collided byte as well as a clean one
          flag_set[FI_DONE] = 1'b1;
          next_r.st        = ST_HOLD_DATA;
        end
      end
      ST_IDLE, ST_WAIT_START:
      begin
        next_r.st = r.st;
      end
      default:
      begin
        next_r.st = ST_IDLE;
      end
    endcase

    if (line.start)
    begin
      flag_clr[FI_CLASH] = 1'b1;
      if (berr_ok && is_shift(r.st) && r.bit_cnt != 4'h0)
        flag_set[FI_BERR] = 1'b1;
      next_r.bit_cnt   = 4'h0;
      next_r.from_addr = 1'b0;
      next_r.st        = r.slv_ctrl[CTL_ENABLE] ? ST_RX_ADDR : ST_IDLE;
    end
    else if (line.stop)
    begin
      if (berr_ok && is_shift(r.st) && (r.bit_cnt != 4'h0 || r.st == ST_RX_ADDR))
        flag_set[FI_BERR] = 1'b1;
      if (r.slv_ctrl[CTL_STOP] && r.st != ST_IDLE)
      begin
        flag_set[FI_ADST]         = 1'b1;
        next_r.addr_or_stop_cause = 1'b0;
      end
      next_r.bit_cnt = 4'h0;
      next_r.st      = ST_IDLE;
    end

    flag_nx = flag_set | (flag_q & ~flag_clr);
    // Hold SCL while a pending interrupt waits in a hold state
    next_r.scl_oe = is_hold(next_r.st)
                    && (flag_nx[FI_DONE] || flag_nx[FI_ADST]);
    // A collision mutes every low level for the rest of the transfer
    next_r.sda_oe = !flag_nx[FI_CLASH]
                    && ((next_r.st == ST_ACK_OUT && !ack_val)
                        || (next_r.st == ST_TX_BYTE && !next_r.shreg[7]));
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r                   <= '0;
      r.st                <= ST_IDLE;
      r.after_ack         <= ST_IDLE;
      r.own_address       <= RST_OWN_ADDR;
      r.slv_ctrl          <= RST_SLV_CTRL;
      r.shreg             <= RST_SHIFT_DATA;
      r.ack_action_select <= RST_ACK_SEL;
    end
    else
      r <= next_r;
  end

  assign reg_rdata = r.rdata;
  assign scl_oe    = r.scl_oe;
  assign sda_oe    = r.sda_oe;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_cmd_rd;
    reg_rd && hit(reg_addr, OFF_CMD_CTRL);
  endsequence

  function automatic logic valid_cmd_wr();
    valid_cmd_wr = reg_wr && hit(reg_addr, OFF_CMD_CTRL)
                   && reg_wdata[1:0] inside {COMPLETE_TRANSACTION_CODE, RESPONSE_CODE};
  endfunction

  sequence s_addr_done;
    addr_hit ##1 flag_q[FI_ADST];
  endsequence

  property p_cmd_reads_zero;
    s_cmd_rd |=> reg_rdata[1:0] == 2'h0;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command field read back nonzero");

  property p_ack_persists;
    !(reg_wr && hit(reg_addr, OFF_CMD_CTRL)) |=> $stable(r.ack_action_select);
  endproperty
  a_ack_persists: assert property (p_ack_persists)
    else $error("ack select changed without a write");

  property p_hold_needs_flag;
    scl_oe |-> (flag_q[FI_DONE] || flag_q[FI_ADST]) && is_hold(r.st);
  endproperty
  a_hold_needs_flag: assert property (p_hold_needs_flag)
    else $error("SCL held without pending flag");

  property p_clash_mutes_sda;
    flag_q[FI_CLASH] |-> !sda_oe;
  endproperty
  a_clash_mutes_sda: assert property (p_clash_mutes_sda)
    else $error("SDA driven low after collision");

  property p_start_clears_clash;
    line.start |=> !flag_q[FI_CLASH];
  endproperty
  a_start_clears_clash: assert property (p_start_clears_clash)
    else $error("collision survived a start");

  property p_cmd_clears_done;
    valid_cmd_wr() && !flag_set[FI_DONE] |=> !flag_q[FI_DONE];
  endproperty
  a_cmd_clears_done: assert property (p_cmd_clears_done)
    else $error("data-done not cleared by command");

  property p_addr_status;
    s_addr_done |-> r.addr_or_stop_cause && r.dir == $past(r.shreg[0], 2) && scl_oe;
  endproperty
  a_addr_status: assert property (p_addr_status)
    else $error("address status wrong after match");

  property p_stop_flag;
    line.stop && r.slv_ctrl[CTL_STOP] && r.st != ST_IDLE
      |=> flag_q[FI_ADST] && !r.addr_or_stop_cause && !scl_oe;
  endproperty
  a_stop_flag: assert property (p_stop_flag)
    else $error("stop did not set address-or-stop flag");

  // Any stop before the address byte completes follows a start too closely
  property p_start_stop_berr;
    r.st == ST_RX_ADDR && line.stop && r.slv_ctrl[CTL_BERR]
      |=> flag_q[FI_BERR] ##1 flag_q[FI_BERR];
  endproperty
  a_start_stop_berr: assert property (p_start_stop_berr)
    else $error("start then stop missed bus error");

endmodule // isc_slave

// ==== isc_pkg.sv ====
// Shared constants, register map and state encoding of the serial bus slave
package isc_pkg;

  localparam int unsigned ADDR_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_SLV_CTRL   = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_CMD_CTRL   = 4'ha;
  localparam logic [ADDR_W-1:0] OFF_FLAGS      = 4'hb;
  localparam logic [ADDR_W-1:0] OFF_OWN_ADDR   = 4'hc;
  localparam logic [ADDR_W-1:0] OFF_SHIFT_DATA = 4'hd;

  // Slave control fields
  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned CTL_SMART  = 1;
  localparam int unsigned CTL_BERR   = 3;
  localparam int unsigned CTL_STOP   = 5;

  // Command control fields
  localparam int unsigned CMD_ACK_BIT = 2;
  localparam logic [1:0]  NO_ACTION_CODE            = 2'h0;
  localparam logic [1:0]  RESERVED_CODE             = 2'h1;
  localparam logic [1:0]  COMPLETE_TRANSACTION_CODE = 2'h2;
  localparam logic [1:0]  RESPONSE_CODE             = 2'h3;

  // Flag register fields
  localparam int unsigned FLG_DATA_DONE  = 7;
  localparam int unsigned FLG_ADDR_STOP  = 6;
  localparam int unsigned FLG_STRETCH    = 5;
  localparam int unsigned FLG_RX_ACK     = 4;
  localparam int unsigned FLG_COLLISION  = 3;
  localparam int unsigned FLG_BUS_ERROR  = 2;
  localparam int unsigned FLG_DIR        = 1;
  localparam int unsigned FLG_CAUSE      = 0;

  // Index of each sticky flag in the flag bank
  localparam int unsigned NUM_FLAGS = 4;
  localparam int unsigned FI_DONE   = 0;
  localparam int unsigned FI_ADST   = 1;
  localparam int unsigned FI_CLASH  = 2;
  localparam int unsigned FI_BERR   = 3;

  // Values after reset
  localparam logic [7:0] RST_OWN_ADDR   = 8'h00;
  localparam logic [7:0] RST_SLV_CTRL   = 8'h00;
  localparam logic [7:0] RST_SHIFT_DATA = 8'h00;
  localparam logic       RST_ACK_SEL    = 1'h0;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Gray coded along idle, address, hold, ack, receive, hold, transmit, ack-in
  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_RX_ADDR    = 4'h1,
    ST_HOLD_ADDR  = 4'h3,
    ST_ACK_OUT    = 4'h2,
    ST_RX_BYTE    = 4'h6,
    ST_HOLD_DATA  = 4'h7,
    ST_TX_BYTE    = 4'h5,
    ST_ACK_IN     = 4'h4,
    ST_WAIT_START = 4'hc
  } isc_state_t;

endpackage

// ==== isc_line_if.sv ====
// Bus line events passed from the line detector to the slave core
`timescale 1ns/1ns
interface isc_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport det  (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// ==== isc_line_det.sv ====
// Pin synchroniser and start, stop and clock edge detector
`timescale 1ns/1ns
module isc_line_det
  import isc_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  isc_line_if.det   line
);

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_d;
    logic       sda_d;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
  } isc_det_state_t;

  isc_det_state_t r;
  isc_det_state_t next_r;

  always_comb
  begin
    next_r       = r;
    next_r.scl_s = {r.scl_s[0], scl_in};
    next_r.sda_s = {r.sda_s[0], sda_in};
    // Only the second stage feeds the detectors
    next_r.scl_d = r.scl_s[1];
    next_r.sda_d = r.sda_s[1];
    next_r.rise  = r.scl_s[1] & ~r.scl_d;
    next_r.fall  = ~r.scl_s[1] & r.scl_d;
    next_r.start = r.scl_s[1] & r.scl_d & r.sda_d & ~r.sda_s[1];
    next_r.stop  = r.scl_s[1] & r.scl_d & ~r.sda_d & r.sda_s[1];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'h1, sda_d: 1'h1, default: 1'h0};
    else
      r <= next_r;
  end

  assign line.scl_rise = r.rise;
  assign line.scl_fall = r.fall;
  assign line.start    = r.start;
  assign line.stop     = r.stop;
  assign line.sda      = r.sda_d;

endmodule // isc_line_det

// ==== isc_flag.sv ====
// Sticky status flag where a set beats a simultaneous clear
`timescale 1ns/1ns
module isc_flag
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  typedef struct packed {
    logic q;
  } isc_flag_state_t;

  isc_flag_state_t r;
  isc_flag_state_t next_r;

  always_comb
  begin
    next_r   = r;
    next_r.q = set | (r.q & ~clr);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.q;

endmodule // isc_flag

// ==== isc_master_model.sv ====
// Behavioural two-wire bus master on open-drain lines
`timescale 1ns/1ns
module isc_master_model
(
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // SDA falls while SCL high, SCL left low
  task automatic start_cond();
    sda_oe = 1'b0;
    #40;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #80;
    sda_oe = 1'b1;
    #80;
    scl_oe = 1'b1;
    #40;
  endtask

  // SDA rises while SCL high, lines left released
  task automatic stop_cond();
    sda_oe = 1'b1;
    #80;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #80;
    sda_oe = 1'b0;
    #80;
  endtask

  // 160 ns bit, low phase long so the slave moves SDA before the rise
  task automatic bit_x(input logic b, output logic s);
    sda_oe = ~b;
    #80;
    scl_oe = 1'b0;
    wait (scl === 1'b1);
    #20;
    s = sda;
    #20;
    scl_oe = 1'b1;
    #40;
  endtask

  task automatic byte_x(input logic [7:0] d, input logic ack, output logic [7:0] s,
                        output logic sa);
    logic t;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], t);
      s[i] = t;
    end
    bit_x(ack, sa);
  endtask
endmodule // isc_master_model

// ==== i2c_slave_command_status_bench.sv ====
// Self-checking bench of the serial bus slave command and status logic
`timescale 1ns/1ns
module i2c_slave_command_status_bench;
  import isc_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic              reg_wr;
  logic              reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, f, r;
  logic              a, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
  wire               scl_w = ~(scl_oe | m_scl_oe);
  wire               sda_w = ~(sda_oe | m_sda_oe);
  int                miscompares = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  isc_slave dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
  isc_master_model m (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    f = reg_rdata;
  endtask

  task automatic rdc(input logic [3:0] ad, input logic [7:0] mk, input logic [7:0] e,
                     input string n);
    rd(ad);
    check(n, f & mk, e);
  endtask

  task automatic wait_flag(input int b);
    repeat (4000)
    begin
      rd(OFF_FLAGS);
      if (f[b] === 1'b1)
        break;
    end
  endtask

  task automatic results();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    sys_rst   = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = '0;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(OFF_FLAGS, 8'hff, 8'h00, "flags");
    rdc(OFF_OWN_ADDR, 8'hff, 8'h00, "own");
    rdc(4'h0, 8'hff, 8'h00, "unmapped");
    wr(OFF_OWN_ADDR, 8'h84);
    rdc(OFF_OWN_ADDR, 8'hff, 8'h84, "own");
    wr(OFF_CMD_CTRL, 8'h04);
    rdc(OFF_CMD_CTRL, 8'hff, 8'h04, "cmd");
    wr(OFF_SLV_CTRL, 8'h29);
    // Master write of one byte, answered with ACK then NACK
    fork
      begin
        m.start_cond();
        m.byte_x(8'h84, 1'b1, r, a);
        check("addr ack", {7'h0, a}, 8'h00);
        m.byte_x(8'ha5, 1'b1, r, a);
        check("data nack", {7'h0, a}, 8'h01);
        m.stop_cond();
      end
      begin
        wait_flag(FLG_ADDR_STOP);
        rdc(OFF_FLAGS, 8'hff, 8'h61, "addr");
        wr(OFF_CMD_CTRL, 8'h03);
        rdc(OFF_FLAGS, 8'he0, 8'h00, "cleared");
        wait_flag(FLG_DATA_DONE);
        rdc(OFF_FLAGS, 8'he0, 8'ha0, "rx done");
        rdc(OFF_SHIFT_DATA, 8'hff, 8'ha5, "rx byte");
        rdc(OFF_FLAGS, 8'h80, 8'h80, "no smart");
        wr(OFF_CMD_CTRL, 8'h06);
        wait_flag(FLG_ADDR_STOP);
        rdc(OFF_FLAGS, 8'h41, 8'h40, "stop");
        wr(OFF_CMD_CTRL, 8'h00); // No-action code 0, not the reserved code
        rdc(OFF_FLAGS, 8'h40, 8'h40, "no act");
        wr(OFF_FLAGS, 8'h40);
        rdc(OFF_FLAGS, 8'h40, 8'h00, "w1c");
      end
    join
    // Master read of two bytes, second one collides; fresh start after
    fork
      begin
        m.start_cond();
        m.byte_x(8'h85, 1'b1, r, a);
        check("read addr ack", {7'h0, a}, 8'h00);
        m.byte_x(8'hff, 1'b0, r, a);
        check("tx byte", r, 8'h3c);
        m.byte_x(8'hef, 1'b1, r, a);
        check("collision_flag byte", r, 8'h2f);
        m.stop_cond();
        m.start_cond();
        m.stop_cond();
      end
      begin
        wait_flag(FLG_ADDR_STOP);
        rdc(OFF_FLAGS, 8'h43, 8'h43, "read addr");
        wr(OFF_CMD_CTRL, 8'h03);
        wait_flag(FLG_DATA_DONE);
        rdc(OFF_FLAGS, 8'he0, 8'ha0, "tx ready");
        for (int k = 0; k < 2; k++)
        begin
          // Second byte starts on the data write alone, in smart mode
          wr(OFF_SHIFT_DATA, 8'h3c);
          if (k == 0)
          begin
            wr(OFF_CMD_CTRL, 8'h03);
            wr(OFF_SLV_CTRL, 8'h2b);
          end
          wait_flag(FLG_DATA_DONE);
          rdc(OFF_FLAGS, 8'h98, k ? 8'h98 : 8'h80, "tx done");
        end
        wr(OFF_CMD_CTRL, 8'h02);
        wait_flag(FLG_ADDR_STOP);
        wr(OFF_FLAGS, 8'h40);
        wait_flag(FLG_BUS_ERROR);
        rdc(OFF_FLAGS, 8'h0c, 8'h04, "bus err");
        wr(OFF_FLAGS, 8'hcc);
        rdc(OFF_FLAGS, 8'hcc, 8'h00, "w1c all");
      end
    join
    // Master pulls SDA low over the NACK that answers its address
    fork
      begin
        m.start_cond();
        m.byte_x(8'h84, 1'b0, r, a);
        m.stop_cond();
      end
      begin
        wait_flag(FLG_ADDR_STOP);
        wr(OFF_CMD_CTRL, 8'h07);
        wait_flag(FLG_COLLISION);
        rdc(OFF_FLAGS, 8'h49, 8'h49, "nack collision_flag");
      end
    join
    results();
  end
endmodule // i2c_slave_command_status_bench
